/* File: rtl/boot_strap_pin_mux.v */
`default_nettype none
`include "pin_mux_defines.vh"
// strap capture, nmi and external interrupts, pci pin takeover
module boot_strap_pin_mux (
    input wire sys_clk,
    input wire srst,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // strap pins
    input wire [1:0] boot_select_pin,
    input wire [1:0] mem_clock_select_pin,
    input wire pci_enable_pin,
    // decoded configuration
    output reg [1:0] boot_source,
    output reg boot_from_host_port,
    output reg boot_from_rom,
    output reg [1:0] mem_clock_source_select,
    output reg use_ext_mem_clock_input,
    output reg mem_clock_tick,
    output reg host_port_active,
    output reg pci_active,
    // interrupts
    input wire nmi_pin,
    output reg nmi_event,
    output reg [3:0] external_irq_event,
    output reg irq,
    // shared pins 4..7
    input wire [3:0] ext_pin_in,
    output reg [3:0] ext_pin_out,
    output reg [3:0] ext_pin_oe,
    // multiplexed pins 9..15, index 0 is pin 9
    input wire [6:0] mux_pin_in,
    output reg [6:0] mux_pin_out,
    output reg [6:0] mux_pin_oe,
    // pci core side
    output reg pci_bus_reset_in,
    output reg pci_bus_clock_in,
    output reg pci_grant_in,
    output reg pci_init_dev_select,
    output reg pci_cmd_byte_enable_3_in,
    input wire core_pci_request,
    input wire core_pci_request_oe,
    input wire core_pci_irq_a,
    input wire core_pci_irq_a_oe,
    input wire core_pci_cbe3,
    input wire core_pci_cbe3_oe
);
    // pin indices inside the multiplexed group
    localparam IDX_IDSEL = 0;
    localparam IDX_CBE3 = 1;
    localparam IDX_REQ = 2;
    localparam IDX_GNT = 3;
    localparam IDX_INTA = 4;
    localparam IDX_PCLK = 5;
    localparam IDX_BUS_RESET = 6;

    reg [1:0] boot_strap;
    reg [1:0] mclk_strap;
    reg pci_strap;
    reg [7:0] irq_enable_bits;
    reg [3:0] ext_irq_polarity_bits;
    reg [15:0] gpio_dir;
    reg [15:0] gpio_out;
    reg [7:0] irq_status;
    reg [7:0] irq_mask;
    reg [7:0] next_irq_status;
    reg [31:0] next_rdata;
    wire [15:0] gpio_in;
    wire [3:0] ext_pulse;
    wire nmi_pulse;
    wire div_tick;
    wire bus_req;
    wire wr_go;

    // byte address match on the word
    function hit;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            hit = (adr[7:2] == ofs[7:2]);
        end
    endfunction

    // merge low two byte lanes of a write into a 16-bit register
    function [15:0] lane_merge;
        input [15:0] old;
        input [15:0] data;
        input [1:0] sel;
        begin
            lane_merge = old;
            if (sel[0])
                lane_merge[7:0] = data[7:0];
            if (sel[1])
                lane_merge[15:8] = data[15:8];
        end
    endfunction

    assign bus_req = wb_cyc_i & wb_stb_i;
    // write lands on the edge that raises ack
    assign wr_go = bus_req & wb_we_i & ~wb_ack_o;

    // sample straps while reset is high, hold afterwards
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            boot_strap <= boot_select_pin;
            mclk_strap <= mem_clock_select_pin;
            pci_strap <= pci_enable_pin;
        end
    end

    // strap decode; reserved codes select nothing, pci takes host port
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            boot_source <= `BOOT_NONE;
            boot_from_host_port <= 1'b0;
            boot_from_rom <= 1'b0;
            mem_clock_source_select <= `MCLK_EXTERNAL;
            use_ext_mem_clock_input <= 1'b0;
            mem_clock_tick <= 1'b0;
            host_port_active <= 1'b0;
            pci_active <= 1'b0;
        end
        else
        begin
            boot_source <= boot_strap;
            boot_from_host_port <= (boot_strap == `BOOT_HOST_PORT);
            boot_from_rom <= (boot_strap == `BOOT_ROM8);
            mem_clock_source_select <= mclk_strap;
            use_ext_mem_clock_input <= (mclk_strap == `MCLK_EXTERNAL);
            mem_clock_tick <= div_tick;
            host_port_active <= ~pci_strap;
            pci_active <= pci_strap;
        end
    end

    mem_clock_divider u_div (
        .sys_clk(sys_clk),
        .srst(srst),
        .mode(mclk_strap),
        .tick(div_tick)
    );

    edge_pulse #(.WIDTH(1)) u_nmi (
        .sys_clk(sys_clk),
        .srst(srst),
        .level(nmi_pin),
        .falling_sel(1'b0),
        .arm(1'b1),
        .pulse(nmi_pulse)
    );

    // armed by enable bits, edge per polarity bit
    edge_pulse #(.WIDTH(4)) u_ext (
        .sys_clk(sys_clk),
        .srst(srst),
        .level(ext_pin_in),
        .falling_sel(ext_irq_polarity_bits),
        .arm(irq_enable_bits[7:4]),
        .pulse(ext_pulse)
    );

    // event pulses, and the level irq taken from next status so it tracks the sticky bits
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            nmi_event <= 1'b0;
            external_irq_event <= 4'h0;
            irq <= 1'b0;
        end
        else
        begin
            nmi_event <= nmi_pulse;
            external_irq_event <= ext_pulse;
            irq <= |(next_irq_status & irq_mask);
        end
    end

    // shared pins: input only after reset or when used as interrupt
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            ext_pin_oe <= 4'h0;
            ext_pin_out <= 4'h0;
        end
        else
        begin
            ext_pin_oe <= gpio_dir[7:4] & ~irq_enable_bits[7:4];
            ext_pin_out <= gpio_out[7:4];
        end
    end

    // multiplexed pins: gpio when pci is off, pci roles otherwise
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            mux_pin_oe <= 7'h00;
            mux_pin_out <= 7'h00;
        end
        else if (!pci_strap)
        begin
            mux_pin_oe <= gpio_dir[15:9];
            mux_pin_out <= gpio_out[15:9];
        end
        else
        begin
            mux_pin_oe <= 7'h00;
            mux_pin_out <= 7'h00;
            mux_pin_oe[IDX_REQ] <= core_pci_request_oe;
            mux_pin_out[IDX_REQ] <= core_pci_request;
            mux_pin_oe[IDX_INTA] <= core_pci_irq_a_oe;
            mux_pin_out[IDX_INTA] <= core_pci_irq_a;
            mux_pin_oe[IDX_CBE3] <= core_pci_cbe3_oe;
            mux_pin_out[IDX_CBE3] <= core_pci_cbe3;
        end
    end

    // pci inputs to the core; all held low when pci is off
    always @(posedge sys_clk)
    begin
        if (srst || !pci_strap)
        begin
            pci_bus_reset_in <= 1'b0;
            pci_bus_clock_in <= 1'b0;
            pci_grant_in <= 1'b0;
            pci_init_dev_select <= 1'b0;
            pci_cmd_byte_enable_3_in <= 1'b0;
        end
        else
        begin
            pci_bus_reset_in <= mux_pin_in[IDX_BUS_RESET];
            pci_bus_clock_in <= mux_pin_in[IDX_PCLK];
            pci_grant_in <= mux_pin_in[IDX_GNT];
            pci_init_dev_select <= mux_pin_in[IDX_IDSEL];
            pci_cmd_byte_enable_3_in <= mux_pin_in[IDX_CBE3];
        end
    end

    // gpio input image; pins taken by pci read as zero
    assign gpio_in = {mux_pin_in & {7{~pci_strap}}, 1'b0, ext_pin_in, 4'h0};

    // sticky status: a new event wins over a clear in the same cycle
    always @*
    begin
        next_irq_status = irq_status;
        if (wr_go && hit(wb_adr_i, `OFS_IRQ_CLEAR) && wb_sel_i[0])
            next_irq_status = irq_status & ~wb_dat_i[7:0];
        next_irq_status[`IRQ_NMI_BIT] = next_irq_status[`IRQ_NMI_BIT] | nmi_pulse;
        next_irq_status[7:4] = next_irq_status[7:4] | ext_pulse;
    end

    // control registers and status
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            irq_enable_bits <= `RST_IRQ_ENABLE_BITS;
            ext_irq_polarity_bits <= `RST_EXT_POLARITY;
            gpio_dir <= `RST_GPIO_DIR;
            gpio_out <= `RST_GPIO_OUT;
            irq_mask <= `RST_IRQ_MASK;
            irq_status <= 8'h00;
        end
        else
        begin
            irq_status <= next_irq_status;
            if (wr_go && hit(wb_adr_i, `OFS_IRQ_ENABLE_BITS) && wb_sel_i[0])
                irq_enable_bits <= {wb_dat_i[7:4], 4'h0};
            if (wr_go && hit(wb_adr_i, `OFS_EXT_POLARITY) && wb_sel_i[0])
                ext_irq_polarity_bits <= wb_dat_i[3:0];
            if (wr_go && hit(wb_adr_i, `OFS_GPIO_DIR))
                gpio_dir <= lane_merge(gpio_dir, wb_dat_i[15:0], wb_sel_i[1:0]) & 16'hfef0;
            if (wr_go && hit(wb_adr_i, `OFS_GPIO_OUT))
                gpio_out <= lane_merge(gpio_out, wb_dat_i[15:0], wb_sel_i[1:0]) & 16'hfef0;
            if (wr_go && hit(wb_adr_i, `OFS_IRQ_MASK) && wb_sel_i[0])
                irq_mask <= wb_dat_i[7:0] & 8'hf1;
        end
    end

    // read mux; unmapped and write-only words read zero
    always @*
    begin
        next_rdata = 32'h00000000;
        if (hit(wb_adr_i, `OFS_STRAP))
            next_rdata[4:0] = {pci_strap, mclk_strap, boot_strap};
        else if (hit(wb_adr_i, `OFS_IRQ_ENABLE_BITS))
            next_rdata[7:0] = irq_enable_bits;
        else if (hit(wb_adr_i, `OFS_EXT_POLARITY))
            next_rdata[3:0] = ext_irq_polarity_bits;
        else if (hit(wb_adr_i, `OFS_GPIO_DIR))
            next_rdata[15:0] = gpio_dir;
        else if (hit(wb_adr_i, `OFS_GPIO_OUT))
            next_rdata[15:0] = gpio_out;
        else if (hit(wb_adr_i, `OFS_GPIO_IN))
            next_rdata[15:0] = gpio_in;
        else if (hit(wb_adr_i, `OFS_IRQ_STATUS))
            next_rdata[7:0] = irq_status;
        else if (hit(wb_adr_i, `OFS_IRQ_MASK))
            next_rdata[7:0] = irq_mask;
    end

    // single-wait ack; dropped the cycle after it was given
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= (bus_req & ~wb_ack_o & ~wb_we_i) ? next_rdata : 32'h00000000;
        end
    end

endmodule // boot_strap_pin_mux

`default_nettype wire

/* File: rtl/pin_mux_defines.vh */
`ifndef PIN_MUX_DEFINES_VH
`define PIN_MUX_DEFINES_VH

// register byte offsets
`define OFS_STRAP 8'h00
`define OFS_IRQ_ENABLE_BITS 8'h04
`define OFS_EXT_POLARITY 8'h08
`define OFS_GPIO_DIR 8'h0c
`define OFS_GPIO_OUT 8'h10
`define OFS_GPIO_IN 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_CLEAR 8'h1c
`define OFS_IRQ_MASK 8'h20

// strap register fields
`define STRAP_BOOT_LSB 0
`define STRAP_MCLK_LSB 2
`define STRAP_PCI_BIT 4

// boot select codes
`define BOOT_NONE 2'h0
`define BOOT_HOST_PORT 2'h1
`define BOOT_RESERVED 2'h2
`define BOOT_ROM8 2'h3

// memory clock select codes and divider terminal counts
`define MCLK_EXTERNAL 2'h0
`define MCLK_DIV4 2'h1
`define MCLK_DIV6 2'h2
`define MCLK_RESERVED 2'h3
`define MCLK_DIV4_LAST 3'h3
`define MCLK_DIV6_LAST 3'h5

// interrupt status / clear / mask bit positions
`define IRQ_NMI_BIT 0
`define IRQ_EXT_LSB 4

// reset values
`define RST_IRQ_ENABLE_BITS 8'h00
`define RST_EXT_POLARITY 4'h0
`define RST_GPIO_DIR 16'h0000
`define RST_GPIO_OUT 16'h0000
`define RST_IRQ_MASK 8'h00

`endif

/* File: rtl/edge_pulse.v */
`default_nettype none
// one-cycle pulse on a chosen edge of each input line
module edge_pulse #(
    parameter WIDTH = 4
) (
    input wire sys_clk,
    input wire srst,
    input wire [WIDTH-1:0] level,
    input wire [WIDTH-1:0] falling_sel,
    input wire [WIDTH-1:0] arm,
    output reg [WIDTH-1:0] pulse
);
    reg [WIDTH-1:0] prev;

    // previous level, reset low so a high pin after reset reads as a rise
    always @(posedge sys_clk)
    begin
        if (srst)
            prev <= {WIDTH{1'b0}};
        else
            prev <= level;
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_line
            // edge only, never level; disarmed lines stay quiet
            always @(posedge sys_clk)
            begin
                if (srst)
                    pulse[i] <= 1'b0;
                else if (falling_sel[i])
                    pulse[i] <= arm[i] & prev[i] & ~level[i];
                else
                    pulse[i] <= arm[i] & ~prev[i] & level[i];
            end
        end
    endgenerate
endmodule // edge_pulse

`default_nettype wire

/* File: rtl/mem_clock_divider.v */
`default_nettype none
`include "pin_mux_defines.vh"
// clock-enable tick for the memory interface at cpu/4 or cpu/6
module mem_clock_divider (
    input wire sys_clk,
    input wire srst,
    input wire [1:0] mode,
    output reg tick
);
    reg [2:0] count;
    reg [2:0] last;
    reg active;

    // terminal count per mode; external and reserved give no tick
    always @*
    begin
        last = `MCLK_DIV4_LAST;
        active = 1'b0;
        case (mode)
            `MCLK_DIV4:
            begin
                last = `MCLK_DIV4_LAST;
                active = 1'b1;
            end
            `MCLK_DIV6:
            begin
                last = `MCLK_DIV6_LAST;
                active = 1'b1;
            end
            default:
            begin
                last = `MCLK_DIV4_LAST;
                active = 1'b0;
            end
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (srst || !active)
        begin
            count <= 3'h0;
            tick <= 1'b0;
        end
        else if (count == last)
        begin
            count <= 3'h0;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 3'h1;
            tick <= 1'b0;
        end
    end
endmodule // mem_clock_divider

`default_nettype wire

/* File: tb/pin_mux_props.sv */
`default_nettype none
module pin_mux_props (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [1:0] boot_source,
    input wire logic boot_from_host_port,
    input wire logic boot_from_rom,
    input wire logic [1:0] mem_clock_source_select,
    input wire logic use_ext_mem_clock_input,
    input wire logic mem_clock_tick,
    input wire logic host_port_active,
    input wire logic pci_active,
    input wire logic nmi_pin,
    input wire logic nmi_event,
    input wire logic [3:0] ext_pin_oe,
    input wire logic [6:0] mux_pin_in,
    input wire logic [6:0] mux_pin_oe,
    input wire logic pci_bus_reset_in,
    input wire logic core_pci_request_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // bus and divider step sequences
    sequence wb_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence gap4;
        !mem_clock_tick [*3] ##1 mem_clock_tick;
    endsequence
    sequence gap6;
        !mem_clock_tick [*5] ##1 mem_clock_tick;
    endsequence
    AST_WB_ACK: assert property (wb_take |=> ack_pulse)
        else $error("ack not a single pulse after request");
    AST_BOOT_DEC: assert property (boot_from_rom == (boot_source == 2'h3) &&
        boot_from_host_port == (boot_source == 2'h1)) else $error("boot decode wrong");
    AST_MCLK_DEC: assert property (!$past(srst) |-> use_ext_mem_clock_input ==
        (mem_clock_source_select == 2'h0)) else $error("clock source decode wrong");
    AST_TICK4: assert property (mem_clock_source_select == 2'h1 && mem_clock_tick |=> gap4)
        else $error("divide by four spacing wrong");
    AST_TICK6: assert property (mem_clock_source_select == 2'h2 && mem_clock_tick |=> gap6)
        else $error("divide by six spacing wrong");
    AST_NO_TICK: assert property (mem_clock_source_select[1] == mem_clock_source_select[0]
        |-> !mem_clock_tick) else $error("tick without divider");
    AST_NMI_RISE: assert property ($rose(nmi_pin) |-> ##[1:3] nmi_event)
        else $error("nmi rise missed");
    AST_NMI_LEVEL: assert property (nmi_pin [*5] |-> !nmi_event)
        else $error("nmi taken on level");
    AST_OE_RST: assert property ($past(srst) |-> ext_pin_oe == 4'h0 && mux_pin_oe == 7'h00)
        else $error("pin driven after reset");
    AST_HOST_PCI: assert property (!$past(srst) |-> host_port_active == !pci_active)
        else $error("host port and pci both or neither");
    AST_STRAP_HOLD: assert property (!$past(srst) && !$past(srst, 2) |->
        $stable(boot_source) && $stable(mem_clock_source_select) && $stable(pci_active))
        else $error("strap value moved outside reset");
    AST_PCI_OUT: assert property (pci_active && $past(pci_active) |->
        mux_pin_oe[2] == $past(core_pci_request_oe)) else $error("request enable wrong");
    AST_PCI_IN: assert property (pci_active && $past(pci_active) |->
        pci_bus_reset_in == $past(mux_pin_in[6]) && !mux_pin_oe[6])
        else $error("pci reset input path wrong");
    AST_PCI_OFF: assert property (!pci_active && !$past(srst) |-> !pci_bus_reset_in)
        else $error("pci input seen while host port owns pins");
endmodule // pin_mux_props
`default_nettype wire

/* File: tb/board_side.sv */
`default_nettype none
module board_side (
    input wire logic [4:0] strap_code,
    input wire logic nmi_src,
    input wire logic [3:0] ext_src,
    input wire logic [6:0] mux_src,
    input wire logic [3:0] ext_pin_out,
    input wire logic [3:0] ext_pin_oe,
    input wire logic [6:0] mux_pin_out,
    input wire logic [6:0] mux_pin_oe,
    output logic [1:0] boot_select_pin,
    output logic [1:0] mem_clock_select_pin,
    output logic pci_enable_pin,
    output logic nmi_pin,
    output logic [3:0] ext_pin_in,
    output logic [6:0] mux_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    assign {pci_enable_pin, mem_clock_select_pin, boot_select_pin} = strap_code;
    assign nmi_pin = nmi_src;
    // device driver wins; else the board source, pulls folded into it
    assign ext_pin_in = (ext_pin_oe & ext_pin_out) | (~ext_pin_oe & ext_src);
    assign mux_pin_in = (mux_pin_oe & mux_pin_out) | (~mux_pin_oe & mux_src);
endmodule // board_side
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
`include "pin_mux_defines.vh"
`define CHK(nm, e, g) \
begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
        err_total++; \
        $display("FAIL %s exp %0h got %0h", nm, e, g); \
    end \
end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic nmi_src = 1'b0, core_pci_request = 1'b0, core_pci_request_oe = 1'b0;
    logic core_pci_irq_a = 1'b0, core_pci_irq_a_oe = 1'b0, core_pci_cbe3 = 1'b0;
    logic core_pci_cbe3_oe = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0, ext_src = 4'h2;
    logic [31:0] wb_dat_i = 32'h0, q;
    logic [4:0] strap_code = 5'h00, code;
    logic [6:0] mux_src = 7'h00;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, boot_from_host_port, boot_from_rom, use_ext_mem_clock_input;
    wire logic mem_clock_tick, host_port_active, pci_active, nmi_event, irq, nmi_pin;
    wire logic pci_bus_reset_in, pci_bus_clock_in, pci_grant_in, pci_init_dev_select;
    wire logic pci_cmd_byte_enable_3_in, pci_enable_pin;
    wire logic [1:0] boot_source, mem_clock_source_select, boot_select_pin, mem_clock_select_pin;
    wire logic [3:0] external_irq_event, ext_pin_in, ext_pin_out, ext_pin_oe;
    wire logic [6:0] mux_pin_in, mux_pin_out, mux_pin_oe;
    int err_total = 0, checks_done = 0, t, nmi_cnt = 0, e4_cnt = 0, e5_cnt = 0, e67_cnt = 0;

    boot_strap_pin_mux u_dut (.sys_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .boot_select_pin, .mem_clock_select_pin,
        .pci_enable_pin, .boot_source, .boot_from_host_port, .boot_from_rom,
        .mem_clock_source_select, .use_ext_mem_clock_input, .mem_clock_tick,
        .host_port_active, .pci_active, .nmi_pin, .nmi_event, .external_irq_event, .irq,
        .ext_pin_in, .ext_pin_out, .ext_pin_oe, .mux_pin_in, .mux_pin_out, .mux_pin_oe,
        .pci_bus_reset_in, .pci_bus_clock_in, .pci_grant_in, .pci_init_dev_select,
        .pci_cmd_byte_enable_3_in, .core_pci_request, .core_pci_request_oe, .core_pci_irq_a,
        .core_pci_irq_a_oe, .core_pci_cbe3, .core_pci_cbe3_oe);
    board_side u_board (.strap_code, .nmi_src, .ext_src, .mux_src, .ext_pin_out,
        .ext_pin_oe, .mux_pin_out, .mux_pin_oe, .boot_select_pin, .mem_clock_select_pin,
        .pci_enable_pin, .nmi_pin, .ext_pin_in, .mux_pin_in);

    // 200 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // event pulse counters
    always @(posedge sys_clk)
    begin
        nmi_cnt <= nmi_cnt + (nmi_event === 1'b1);
        e4_cnt <= e4_cnt + (external_irq_event[0] === 1'b1);
        e5_cnt <= e5_cnt + (external_irq_event[1] === 1'b1);
        e67_cnt <= e67_cnt + (external_irq_event[3:2] !== 2'h0);
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one classic cycle; waits on ack, no fixed latency assumed
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        `CHK("ack", 1'b1, wb_ack_o)
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb_xfer(1'b0, a, 32'h0);
        `CHK(nm, e, q)
    endtask

    task automatic do_reset(input logic [4:0] c);
        strap_code <= c;
        srst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #50000;
        err_total++;
        complete_run();
    end

    initial
    begin
        // every boot and clock strap code, pci both ways; straps move after release and must not follow
        for (int i = 0; i < 4; i++)
        begin
            code = {i[0], 2'(3 - i), i[1:0]};
            do_reset(code);
            strap_code <= ~code;
            t = 0;
            repeat (24)
            begin
                @(posedge sys_clk);
                t += (mem_clock_tick === 1'b1);
            end
            `CHK("boot", i[1:0], boot_source)
            `CHK("rom", i == 3, boot_from_rom)
            `CHK("host", i == 1, boot_from_host_port)
            `CHK("mclk", 2'(3 - i), mem_clock_source_select)
            `CHK("ext_clk", i == 3, use_ext_mem_clock_input)
            `CHK("ticks", (i == 2) ? 6 : (i == 1) ? 4 : 0, t)
            `CHK("pci", i[0], pci_active)
            `CHK("hp", !i[0], host_port_active)
            `CHK("oe", 11'h0, {ext_pin_oe, mux_pin_oe})
            rd("strap", `OFS_STRAP, {27'h0, code});
            rd("dir", `OFS_GPIO_DIR, 32'h0);
            rd("unmapped", 8'hfc, 32'h0);
        end
        $display("test straps done");
        // pci owns pins 9..15 after the last strap code
        core_pci_request <= 1'b1;
        core_pci_request_oe <= 1'b1;
        core_pci_irq_a_oe <= 1'b1;
        core_pci_cbe3 <= 1'b1;
        mux_src <= 7'h42;
        repeat (3) @(posedge sys_clk);
        `CHK("req", 2'h3, {mux_pin_oe[2], mux_pin_out[2]})
        `CHK("irq_a_oe", 1'b1, mux_pin_oe[4])
        `CHK("pci_bus_reset_in", 1'b1, pci_bus_reset_in)
        `CHK("cbe3", 2'h1, {mux_pin_oe[1], pci_cmd_byte_enable_3_in})
        `CHK("in_oe", 4'h0, {mux_pin_oe[6:5], mux_pin_oe[3], mux_pin_oe[0]})
        `CHK("pci_in0", 2'h0, {pci_bus_clock_in, pci_grant_in})
        `CHK("pci_in1", 2'h0, {pci_init_dev_select, mux_pin_out[4]})
        rd("gpio_in_pci", `OFS_GPIO_IN, 32'h20);
        $display("test pci done");
        // host port mode: pins 9 and 4 as driven gpio, then interrupts
        do_reset(5'h03);
        wb_xfer(1'b1, `OFS_GPIO_DIR, 32'h210);
        wb_xfer(1'b1, `OFS_GPIO_OUT, 32'h210);
        repeat (2) @(posedge sys_clk);
        `CHK("gp9", 3'h7, {mux_pin_oe[0], mux_pin_out[0], ext_pin_oe[0]})
        wb_xfer(1'b1, `OFS_EXT_POLARITY, 32'h2);
        wb_xfer(1'b1, `OFS_IRQ_ENABLE_BITS, 32'h30);
        repeat (3) @(posedge sys_clk);
        `CHK("irq_pin_oe", 1'b0, ext_pin_oe[0])
        ext_src <= 4'hf;
        nmi_src <= 1'b1;
        repeat (10) @(posedge sys_clk);
        ext_src <= 4'h0;
        nmi_src <= 1'b0;
        repeat (5) @(posedge sys_clk);
        ext_src <= 4'h2;
        repeat (5) @(posedge sys_clk);
        `CHK("nmi", 1, nmi_cnt)
        `CHK("ev4", 1, e4_cnt)
        `CHK("ev5", 1, e5_cnt)
        `CHK("ev67", 0, e67_cnt)
        rd("status", `OFS_IRQ_STATUS, 32'h31);
        `CHK("irq_masked", 1'b0, irq)
        wb_xfer(1'b1, `OFS_IRQ_MASK, 32'h1);
        repeat (3) @(posedge sys_clk);
        `CHK("irq_on", 1'b1, irq)
        wb_xfer(1'b1, `OFS_IRQ_CLEAR, 32'h31);
        repeat (3) @(posedge sys_clk);
        `CHK("irq_off", 1'b0, irq)
        rd("cleared", `OFS_IRQ_STATUS, 32'h0);
        $display("test interrupts done");
        complete_run();
    end
endmodule // tb
bind boot_strap_pin_mux pin_mux_props u_props (.sys_clk, .srst, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .boot_source, .boot_from_host_port, .boot_from_rom, .mem_clock_source_select,
    .use_ext_mem_clock_input, .mem_clock_tick, .host_port_active, .pci_active, .nmi_pin,
    .nmi_event, .ext_pin_oe, .mux_pin_in, .mux_pin_oe, .pci_bus_reset_in,
    .core_pci_request_oe);
`default_nettype wire
